// ### logic/line_drive_pkg.sv
`default_nettype none
package line_drive_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int POWERUP_US = 1000; // settle time after power-down release
	localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
	localparam int MCLK_LOSS_US = 1000; // master clock silent time
	localparam int MCLK_LOSS_CYC = MCLK_LOSS_US * CLK_MHZ;
	localparam int HWRST_NS = 2000; // least low time of hardware reset
	localparam int HWRST_CYC = (HWRST_NS + 9) / 10;
	localparam int TCLK_LOSS_LINE_RATE_CLOCK = 64; // transmit clock silent line-rate cycles
	// line rates in kHz, derived by fractional accumulator
	localparam int T1_RATE_KHZ = 1544;
	localparam int E1_RATE_KHZ = 2048;
	localparam int CLK_KHZ = CLK_MHZ * 1000;

	// ------------------------------------------------------------
	// field positions of the transmit configuration
	// ------------------------------------------------------------
	localparam int TERM_LSB = 0;
	localparam int SINGLE_BIT = 3;
	localparam int OCFLOAT_BIT = 4;
	localparam int TXOFF_BIT = 5;
	localparam int DRIVE_EN_BIT = 6;
	localparam logic [7:0] TX_CONFIG_RESET = 8'h40;

	// termination select codes
	typedef enum logic [2:0] {
		TERM_T1_100 = 3'h0,
		TERM_J1_110 = 3'h1,
		TERM_E1_120 = 3'h2,
		TERM_E1_75 = 3'h3,
		TERM_T1_NOXF = 3'h4,
		TERM_J1_NOXF = 3'h5,
		TERM_E1_NOXF = 3'h6,
		TERM_E1_EXT = 3'h7
	} term_e;

	// transmit system format
	typedef enum logic [1:0] {
		FMT_SINGLE_NRZ = 2'h0,
		FMT_DUAL_NRZ = 2'h1,
		FMT_AMI_RZ = 2'h2
	} tx_format_e;

	// per-channel transmit configuration
	typedef struct packed {
		logic drive_enable;
		logic tx_power_down;
		logic overcurrent_float_select;
		logic single_ended_select;
		logic [2:0] term_select;
	} tx_config_s;

	// per-channel line pin drive
	typedef struct packed {
		logic tip;
		logic tip_oe;
		logic ring;
		logic ring_oe;
		logic mf_oe;
		logic current_limit;
	} line_drive_s;
endpackage
`default_nettype wire

// ### logic/activity_watch.sv
`timescale 1ns/1ns
`default_nettype none
// watches a sampled clock for edges; flags loss after more than LIMIT ticks without one
module activity_watch
	import line_drive_pkg::*;
#(
	parameter int LIMIT = 64
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// watched signal and counting enable
	input wire logic watched,
	input wire logic tick,
	input wire logic hold,
	// result
	output logic lost
);
	initial begin
		if (LIMIT < 1) $error("activity_watch: LIMIT must be positive");
	end
	localparam int W = $clog2(LIMIT + 2);
	localparam logic [W-1:0] LIM = W'(LIMIT);

	logic prev_reg;
	logic [W-1:0] count_reg;
	logic lost_reg;
	wire edge_seen = watched ^ prev_reg;
	wire at_limit = count_reg >= LIM;

	// edge detect and silence counter
	always_ff @(posedge clk) begin
		if (!rst_n || hold) begin
			prev_reg <= 1'b0;
			count_reg <= '0;
			lost_reg <= 1'b0;
		end else begin
			prev_reg <= watched;
			if (edge_seen) begin
				count_reg <= '0;
				lost_reg <= 1'b0;
			end else if (tick && !at_limit) begin
				count_reg <= count_reg + W'(1);
			end else if (tick && at_limit) begin
				lost_reg <= 1'b1; // more than LIMIT ticks silent
			end
		end
	end
	assign lost = lost_reg;
endmodule
`default_nettype wire

// ### logic/line_driver_output_control.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// RQ1: global enable pin low floats every channel's tip and ring.
// RQ2: channel drive enable bit zero floats only that channel.
// RQ3: pin and bit float outputs immediately; internal logic keeps running.
// RQ4: over-current limits current, or floats outputs when float select set.
// RQ5: over-current state bit; event flag by level or either edge.
// RQ6: interrupt output high while unmasked over-current event flag set.
// RQ7: single-ended select drives tip only; otherwise tip and ring.
// RQ8: software programs termination code per cable and matching table.
// RQ9: single-ended mode needs termination code 011 from software.
// RQ10: differential T1/J1 internal matching only; E1 internal or external.
// RQ11: power-down floats tip, ring, multifunction; ignores data and clock.
// RQ12: after power-down release, steady operation within 1 ms.
// RQ13: master clock silent over 1 ms floats all channels.
// RQ14: power-on, hardware reset over 2 us, global soft reset float all.
// RQ15: NRZ formats: transmit clock silent over 64 line cycles floats channel.
// RQ16: channel soft reset resets that channel and floats its outputs.
// RQ17: line-rate clock from master clock at 1.544 or 2.048 MHz; code derives the tick from clk instead.
// RQ18: software picks E1 pulse template 0000 coax, 0001 otherwise.
// RQ19: channel enable is AND of negated global and channel float causes.
module line_driver_output_control
	import line_drive_pkg::*;
#(
	parameter int CHANNELS = 21,
	parameter int POWERUP_CYCLES = POWERUP_CYC,
	parameter int MCLK_LOSS_CYCLES = MCLK_LOSS_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// global controls
	input wire logic output_enable, // pin, high drives
	input wire logic hw_reset_n, // pin, sampled
	input wire logic global_soft_reset, // one-cycle write pulse
	input wire logic e1_mode,
	input wire logic master_clock, // sampled reference
	// per-channel configuration
	input wire tx_config_s [CHANNELS-1:0] tx_config,
	input wire logic [CHANNELS-1:0] channel_soft_reset, // one-cycle write pulse
	input wire logic [1:0] tx_format [CHANNELS],
	input wire logic [CHANNELS-1:0] remote_loopback,
	input wire logic [CHANNELS-1:0] internal_pattern,
	input wire logic [CHANNELS-1:0] overcurrent_edge_select,
	input wire logic [CHANNELS-1:0] overcurrent_event_mask,
	input wire logic [CHANNELS-1:0] overcurrent_event_clear, // one-cycle pulse
	// per-channel line side
	input wire logic [CHANNELS-1:0] tx_overcurrent,
	input wire logic [CHANNELS-1:0] tx_system_clock,
	input wire logic [CHANNELS-1:0] tx_data_pos,
	input wire logic [CHANNELS-1:0] tx_data_neg,
	output line_drive_s [CHANNELS-1:0] line_drive,
	// status
	output logic [CHANNELS-1:0] overcurrent_state,
	output logic [CHANNELS-1:0] overcurrent_event_flag,
	output logic [CHANNELS-1:0] tx_ready,
	output logic line_rate_tick,
	output logic interrupt_req
);
	initial begin
		if (CHANNELS < 1 || CHANNELS > 32) $error("CHANNELS out of range");
		if (POWERUP_CYCLES < 1 || MCLK_LOSS_CYCLES < 1) $error("counts must be positive");
	end

	// ------------------------------------------------------------
	// line-rate tick
	// ------------------------------------------------------------
	logic [17:0] phase_reg;
	logic [17:0] phase_next;
	logic [17:0] step;
	logic [18:0] phase_sum;
	// RQ17 fractional line rate
	assign step = e1_mode ? 18'(E1_RATE_KHZ) : 18'(T1_RATE_KHZ);
	assign phase_sum = {1'b0, phase_reg} + {1'b0, step};
	assign phase_next = (phase_sum >= 19'(CLK_KHZ)) ? 18'(phase_sum - 19'(CLK_KHZ)) : phase_sum[17:0];
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phase_reg <= '0;
			line_rate_tick <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			line_rate_tick <= (phase_sum >= 19'(CLK_KHZ));
		end
	end

	// ------------------------------------------------------------
	// global float causes
	// ------------------------------------------------------------
	logic mclk_lost;
	logic [$clog2(HWRST_CYC+2)-1:0] hwrst_cnt_reg;
	logic hwrst_float_reg;
	logic soft_float_reg;
	logic global_float;

	// RQ13 master clock watch
	activity_watch #(
		.LIMIT(MCLK_LOSS_CYCLES)
	) mclk_watch (
		.clk(clk),
		.rst_n(rst_n),
		.watched(master_clock),
		.tick(1'b1),
		.hold(1'b0),
		.lost(mclk_lost)
	);

	// RQ14 hardware reset held long enough
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hwrst_cnt_reg <= '0;
			hwrst_float_reg <= 1'b1;
			soft_float_reg <= 1'b1;
		end else begin
			if (hw_reset_n)
				hwrst_cnt_reg <= '0;
			else if (!hwrst_float_reg)
				hwrst_cnt_reg <= hwrst_cnt_reg + 1'b1;
			if (hw_reset_n)
				hwrst_float_reg <= 1'b0;
			else if (32'(hwrst_cnt_reg) >= HWRST_CYC)
				hwrst_float_reg <= 1'b1;
			soft_float_reg <= global_soft_reset; // one cycle of reset float
		end
	end

	// RQ1 RQ13 RQ14 global causes
	assign global_float = !output_enable || mclk_lost || hwrst_float_reg || soft_float_reg;

	// ------------------------------------------------------------
	// per-channel logic
	// ------------------------------------------------------------
	logic [CHANNELS-1:0] irq_terms;
	localparam int PW = $clog2(POWERUP_CYCLES + 1);

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
			logic chan_reset;
			logic tclk_lost;
			logic tclk_watch_on;
			logic oc_prev_reg;
			logic oc_flag_reg;
			logic oc_set;
			logic [PW-1:0] settle_reg;
			logic chan_float;
			logic drive_on;
			logic powered;
			logic single;

			// RQ16 channel reset from soft reset and global resets
			assign chan_reset = channel_soft_reset[ch] || soft_float_reg || hwrst_float_reg;
			assign powered = !tx_config[ch].tx_power_down;

			// RQ15 clock watch in NRZ formats, exempt cases excluded
			assign tclk_watch_on = powered && !remote_loopback[ch] && !internal_pattern[ch]
				&& (tx_format[ch] == FMT_SINGLE_NRZ || tx_format[ch] == FMT_DUAL_NRZ);
			// RQ11 clock input ignored while powered down
			activity_watch #(
				.LIMIT(TCLK_LOSS_LINE_RATE_CLOCK)
			) tclk_watch (
				.clk(clk),
				.rst_n(rst_n),
				.watched(tx_system_clock[ch] && powered),
				.tick(line_rate_tick),
				.hold(!tclk_watch_on || chan_reset),
				.lost(tclk_lost)
			);

			// RQ12 settle count after power-down release
			always_ff @(posedge clk) begin
				if (!rst_n || !powered) begin
					settle_reg <= '0;
				end else if (32'(settle_reg) < POWERUP_CYCLES) begin
					settle_reg <= settle_reg + 1'b1;
				end
			end
			assign tx_ready[ch] = powered && (32'(settle_reg) >= POWERUP_CYCLES);

			// RQ5 event flag, set beats clear
			assign overcurrent_state[ch] = tx_overcurrent[ch];
			assign oc_set = overcurrent_edge_select[ch] ? (tx_overcurrent[ch] ^ oc_prev_reg) : tx_overcurrent[ch];
			always_ff @(posedge clk) begin
				if (!rst_n || channel_soft_reset[ch]) begin
					oc_prev_reg <= 1'b0;
					oc_flag_reg <= 1'b0;
				end else begin
					oc_prev_reg <= tx_overcurrent[ch];
					if (oc_set)
						oc_flag_reg <= 1'b1;
					else if (overcurrent_event_clear[ch])
						oc_flag_reg <= 1'b0;
				end
			end
			assign overcurrent_event_flag[ch] = oc_flag_reg;
			// RQ6 unmasked flag drives interrupt
			assign irq_terms[ch] = oc_flag_reg && !overcurrent_event_mask[ch];

			// RQ2 RQ4 RQ11 RQ15 RQ16 channel causes
			assign chan_float = !tx_config[ch].drive_enable || tx_config[ch].tx_power_down || tclk_lost
				|| channel_soft_reset[ch] || (tx_config[ch].overcurrent_float_select && tx_overcurrent[ch]);
			// RQ19 RQ3 combinational enable, immediate
			assign drive_on = !global_float && !chan_float;
			// RQ7 RQ10 tip only when single; matching rides on term code
			assign single = tx_config[ch].single_ended_select;
			assign line_drive[ch].tip_oe = drive_on;
			assign line_drive[ch].ring_oe = drive_on && !single;
			assign line_drive[ch].tip = tx_data_pos[ch] && powered;
			assign line_drive[ch].ring = tx_data_neg[ch] && powered;
			// RQ11 multifunction floats in power-down
			assign line_drive[ch].mf_oe = powered;
			// RQ4 current limit when not floating
			assign line_drive[ch].current_limit = tx_overcurrent[ch] && !tx_config[ch].overcurrent_float_select;
		end
	endgenerate

	// RQ6 interrupt output
	assign interrupt_req = |irq_terms;
endmodule
`default_nettype wire

// ### test/line_load.sv
`timescale 1ns/1ns
`default_nettype none
// line side model: detector level and tip wire level
module line_load
	import line_drive_pkg::*;
(
	// clock
	input wire logic clk,
	// driver side and fault
	input wire line_drive_s drive,
	input wire logic short,
	// detector and wire
	output logic overcurrent,
	output logic tip_level
);
	// ------------------------------------------------------------
	// behaviour
	// ------------------------------------------------------------
	initial begin
		overcurrent = 1'b0;
		tip_level = 1'b0;
	end
	// undriven line wanders, never holds the last bit
	always @(posedge clk) begin
		overcurrent <= short;
		tip_level <= drive.tip_oe ? drive.tip : ~tip_level;
	end
endmodule
`default_nettype wire

// ### test/line_check_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module line_check
	import line_drive_pkg::*;
#(
	parameter int CHANNELS = 21
) (
	// all ports of the block
	input wire logic clk, rst_n, output_enable, hw_reset_n, global_soft_reset, e1_mode, master_clock,
	input wire tx_config_s [CHANNELS-1:0] tx_config,
	input wire logic [1:0] tx_format [CHANNELS],
	input wire logic [CHANNELS-1:0] channel_soft_reset, remote_loopback, internal_pattern,
	input wire logic [CHANNELS-1:0] overcurrent_edge_select, overcurrent_event_mask, overcurrent_event_clear,
	input wire logic [CHANNELS-1:0] tx_overcurrent, tx_system_clock, tx_data_pos, tx_data_neg,
	input wire line_drive_s [CHANNELS-1:0] line_drive,
	input wire logic [CHANNELS-1:0] overcurrent_state, overcurrent_event_flag, tx_ready,
	input wire logic line_rate_tick, interrupt_req
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// channel 0 properties
	// ------------------------------------------------------------
	a_global_pin_float: assert property (!output_enable |-> !line_drive[0].tip_oe && !line_drive[0].ring_oe)
		else $error("pin low but driver on");
	a_chan_bit_float: assert property (!tx_config[0].drive_enable |-> !line_drive[0].tip_oe && !line_drive[0].ring_oe)
		else $error("drive bit low but driver on");
	a_oc_float: assert property (tx_overcurrent[0] && tx_config[0].overcurrent_float_select |-> !line_drive[0].tip_oe)
		else $error("over-current float missing");
	a_oc_limit: assert property (tx_overcurrent[0] && !tx_config[0].overcurrent_float_select |-> line_drive[0].current_limit)
		else $error("current limit missing");
	a_oc_state: assert property (overcurrent_state[0] == tx_overcurrent[0])
		else $error("state differs from detector");
	a_flag_level: assert property (tx_overcurrent[0] && !overcurrent_edge_select[0] && !channel_soft_reset[0]
		|=> overcurrent_event_flag[0])
		else $error("level flag not set");
	a_irq_unmasked: assert property (overcurrent_event_flag[0] && !overcurrent_event_mask[0] |-> interrupt_req)
		else $error("interrupt missing");
	a_single_ring: assert property (tx_config[0].single_ended_select |-> !line_drive[0].ring_oe)
		else $error("ring driven in single-ended");
	a_power_float: assert property (tx_config[0].tx_power_down |-> !line_drive[0].tip_oe && !line_drive[0].mf_oe)
		else $error("powered-down channel drives");
	a_soft_float: assert property (channel_soft_reset[0] |-> !line_drive[0].tip_oe)
		else $error("soft reset left driver on");
	c_irq: cover property (interrupt_req);
	c_limit: cover property (line_drive[0].current_limit);
	c_ready: cover property (!tx_ready[0] ##1 tx_ready[0]);
endmodule
bind line_driver_output_control line_check #(.CHANNELS(CHANNELS)) u_chk (.*);
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	import line_drive_pkg::*;
	logic clk = 0, rst_n = 0, oe = 1, hwr = 1, gsr = 0, mclk = 0, mrun = 1, trun = 1, e1 = 0, tick, irq;
	logic [1:0] csr = 0, rlb = 0, ip = 0, ies = 0, msk = 0, clr = 0, short = 0, tclk = 0, oc, st, flg, rdy;
	logic [1:0] fmt [2];
	tx_config_s [1:0] cfg;
	line_drive_s [1:0] ld;
	int num_errors = 0, cmp_count = 0, cyc = 0, ticks = 0, t0 = 0;
	// ------------------------------------------------------------
	// clock, free clocks, timeout
	// ------------------------------------------------------------
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		ticks <= ticks + int'(tick);
		if (mrun) mclk <= ~mclk;
		if (trun) tclk <= ~tclk;
		if (cyc == 40000) begin
			num_errors++;
			test_done();
		end
	end
	line_load p0 (.clk(clk), .drive(ld[0]), .short(short[0]), .overcurrent(oc[0]), .tip_level());
	line_load p1 (.clk(clk), .drive(ld[1]), .short(short[1]), .overcurrent(oc[1]), .tip_level());
	line_driver_output_control #(.CHANNELS(2), .POWERUP_CYCLES(20), .MCLK_LOSS_CYCLES(50)) DUT (
		.clk(clk), .rst_n(rst_n), .output_enable(oe), .hw_reset_n(hwr), .global_soft_reset(gsr),
		.e1_mode(e1), .master_clock(mclk), .tx_config(cfg), .channel_soft_reset(csr), .tx_format(fmt),
		.remote_loopback(rlb), .internal_pattern(ip), .overcurrent_edge_select(ies),
		.overcurrent_event_mask(msk), .overcurrent_event_clear(clr), .tx_overcurrent(oc),
		.tx_system_clock(tclk), .tx_data_pos({2{mclk}}), .tx_data_neg(2'h0), .line_drive(ld),
		.overcurrent_state(st), .overcurrent_event_flag(flg), .tx_ready(rdy), .line_rate_tick(tick),
		.interrupt_req(irq));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse_clr();
		@(posedge clk) clr[0] <= 1;
		@(posedge clk) clr[0] <= 0;
		w(1);
	endtask
	task automatic test_done();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		cfg = {7'h40, 7'h40};
		fmt = '{2'h0, 2'h1};
		w(16);
		@(posedge clk) rst_n <= 1;
		w(30);
		chk("tip0", ld[0].tip_oe, 1);
		@(posedge clk) oe <= 0;
		w(1);
		chk("tip0 pin", ld[0].tip_oe, 0);
		chk("ring1 pin", ld[1].ring_oe, 0);
		@(posedge clk) oe <= 1;
		w(1);
		chk("tip0 back", ld[0].tip_oe, 1);
		@(posedge clk) cfg[0].drive_enable <= 0;
		w(1);
		chk("tip0 bit", ld[0].tip_oe, 0);
		chk("tip1 bit", ld[1].tip_oe, 1);
		// single-ended with coax termination code
		@(posedge clk) cfg[0] <= 7'h4b;
		w(1);
		chk("ring0 se", ld[0].ring_oe, 0);
		chk("tip0 se", ld[0].tip_oe, 1);
		@(posedge clk) cfg[0] <= 7'h40;
		@(posedge clk) short[0] <= 1;
		w(3);
		chk("limit", ld[0].current_limit, 1);
		chk("state", st, 2'h1);
		chk("flag", flg, 2'h1);
		chk("irq", irq, 1);
		@(posedge clk) msk[0] <= 1;
		w(1);
		chk("irq masked", irq, 0);
		@(posedge clk) msk[0] <= 0;
		pulse_clr();
		chk("flag held", flg[0], 1);
		@(posedge clk) cfg[0].overcurrent_float_select <= 1;
		w(1);
		chk("oc float", ld[0].tip_oe, 0);
		@(posedge clk) short[0] <= 0;
		@(posedge clk) ies[0] <= 1;
		w(3);
		pulse_clr();
		chk("flag clear", flg[0], 0);
		@(posedge clk) short[0] <= 1;
		w(3);
		chk("rise flag", flg[0], 1);
		pulse_clr();
		chk("no edge", flg[0], 0);
		@(posedge clk) short[0] <= 0;
		w(3);
		chk("fall flag", flg[0], 1);
		@(posedge clk) cfg[0] <= 7'h60;
		w(1);
		chk("pd tip", ld[0].tip_oe, 0);
		chk("pd mf", ld[0].mf_oe, 0);
		chk("pd data", ld[0].tip, 0);
		@(posedge clk) cfg[0] <= 7'h40;
		w(1);
		chk("settling", rdy[0], 0);
		w(25);
		chk("settled", rdy[0], 1);
		@(posedge clk) mrun <= 0;
		w(60);
		chk("mclk loss", ld[1].tip_oe, 0);
		@(posedge clk) mrun <= 1;
		w(10);
		chk("mclk back", ld[1].tip_oe, 1);
		@(posedge clk) rlb[1] <= 1;
		@(posedge clk) trun <= 0;
		w(1);
		t0 = ticks;
		w(5000);
		chk("line rate", ticks - t0 >= 77 && ticks - t0 <= 78, 1);
		chk("tclk loss", ld[0].tip_oe, 0);
		chk("loopback", ld[1].tip_oe, 1);
		@(posedge clk) trun <= 1;
		w(10);
		chk("tclk back", ld[0].tip_oe, 1);
		// e1 coax internal, 120 ohm external
		@(posedge clk) begin
			cfg <= {7'h47, 7'h43};
			e1 <= 1;
			ip[0] <= 1;
			rlb[1] <= 0;
		end
		@(posedge clk) trun <= 0;
		w(1);
		t0 = ticks;
		w(5000);
		chk("e1 rate", ticks - t0 >= 102 && ticks - t0 <= 103, 1);
		chk("pattern", ld[0].tip_oe, 1);
		chk("dual nrz loss", ld[1].tip_oe, 0);
		@(posedge clk) trun <= 1;
		w(10);
		chk("dual nrz back", ld[1].tip_oe, 1);
		@(posedge clk) csr[0] <= 1;
		w(1);
		chk("csr tip0", ld[0].tip_oe, 0);
		chk("csr tip1", ld[1].tip_oe, 1);
		@(posedge clk) csr[0] <= 0;
		@(posedge clk) gsr <= 1;
		@(posedge clk) gsr <= 0;
		w(1);
		chk("gsr", ld[1].tip_oe, 0);
		@(posedge clk) hwr <= 0;
		w(150);
		chk("hw reset short", ld[1].tip_oe, 1);
		w(100);
		chk("hw reset", ld[1].tip_oe, 0);
		test_done();
	end
endmodule
`default_nettype wire
